// ---- hot_swap_pkg.sv ----
// Constants and types shared by the hot-swap host controller
package hot_swap_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_TIME_NS = 2000;
  localparam int PULSE_CYCLES =
    (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_WIDTH = 16;

  // Gate drive state reported by the device
  localparam logic [1:0] GATE_OFF_STRONG = 2'h0;
  localparam logic [1:0] GATE_OFF_MODERATE = 2'h1;
  localparam logic [1:0] GATE_ON = 2'h2;
  localparam logic [1:0] GATE_LIMITING = 2'h3;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_SHUTDOWN = 3'b001,
    ST_FAULT = 3'b010,
    ST_WAIT_TIMER = 3'b011,
    ST_PULSE = 3'b100,
    ST_SETTLE = 3'b101
  } host_state_type;

  typedef struct packed {
    host_state_type state;
    logic [COUNT_WIDTH-1:0] count;
    logic lockout_low;
    logic supply_off;
    logic fault_latched;
    logic gate_was_on;
    logic restart_done;
    logic load_good;
  } host_regs_type;

  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 16'h0000;
endpackage

// ---- hot_swap_host.sv ----
// Host controller driving the hot-swap device lockout and supply pins
// What this block does
// - Host restarts latched device via lockout or supply
// - Restart attempted only when timer below restart level
// - Host holds lockout low to shut load off
// - Power limit setting may stay unconnected
`timescale 1ns/100ps
module hot_swap_host #(
  parameter bit LATCHED_VARIANT = 1'b1,
  parameter bit RESTART_BY_SUPPLY = 1'b0,
  parameter bit USE_POWER_LIMIT = 1'b0,
  parameter int PULSE_CYCLES = hot_swap_pkg::PULSE_CYCLES,
  parameter int SETTLE_CYCLES = hot_swap_pkg::SETTLE_CYCLES
) (
  input wire logic ref_clk_in, // 10 MHz clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic shutdown_req_in, // User asks load off
  input wire logic restart_req_in, // User asks restart after fault
  input wire logic [1:0] gate_state_in, // Device gate drive state
  input wire logic timer_low_in, // Timer below restart level
  input wire logic power_good_output_in, // Power good pin level
  input wire logic lockout_in, // Lockout pin level seen on wire
  output logic lockout_out, // Lockout pin drive value
  output logic lockout_oe_n_out, // Lockout drive enable, low drives
  output logic supply_enable_out, // Input supply switch enable
  output logic power_limit_set_oe_n_out, // Power limit pin drive
  output logic load_on_out, // Gate on or limiting, as last sampled in RUN
  output logic load_good_out, // Power good seen with lockout high
  output logic fault_out, // Latched fault awaiting restart
  output logic restart_pulse_out, // One cycle at restart release
  output logic busy_out // Restart or shutdown in progress
);
  hot_swap_pkg::host_regs_type r;
  hot_swap_pkg::host_regs_type next_r;

  // State flow
  //   RUN        normal operation, watches the gate for a latched trip
  //   SHUTDOWN   user holds the load off through the lockout pin
  //   FAULT      device latched off, waits for a restart request
  //   WAIT_TIMER waits until the device timer is below restart level
  //   PULSE      lockout pulled low, or supply cut, to restart
  //   SETTLE     device re-runs in-rush limiting, gate edges ignored
  //
  // Hazards
  //   A gate drop during SETTLE is in-rush behaviour, not a fault,
  //   so gate_was_on is cleared on the way back to RUN.
  //   The strong pull-down marks a breaker event, which the device
  //   times by itself; only the moderate pull-down marks a trip.
  //   A moderate pull-down with lockout low is our own shutdown,
  //   so the trip test also asks for lockout released.
  //   A shutdown request during PULSE does not cut the pulse short;
  //   lockout simply stays low once the pulse has ended.
  //   A pulse sent while the device timer is still high is ignored
  //   by the device, hence the wait on the timer-low input.
  //   The auto-restart variant never latches, so FAULT is not
  //   entered there and the device restarts on its own.
  //
  // Limitations
  //   The wait for the timer has no limit of its own; a device that
  //   never discharges its timer leaves the host in WAIT_TIMER.
  //   Inputs are taken as synchronous to the reference clock.

  // Gate on or limiting both mean the switch conducts
  function automatic logic gate_is_on(input logic [1:0] g);
    gate_is_on = (g == hot_swap_pkg::GATE_ON) ||
                 (g == hot_swap_pkg::GATE_LIMITING);
  endfunction

  // Counter end test shared by PULSE and SETTLE
  function automatic logic count_done(input logic [15:0] c,
                                      input int limit);
    count_done = (c >= 16'(limit - 1));
  endfunction

  always_comb begin
    next_r = r;
    next_r.restart_done = 1'b0;
    // Power good only counts while lockout is released
    next_r.load_good = power_good_output_in & lockout_in;
    if (r.state == hot_swap_pkg::ST_RUN) begin
      next_r.gate_was_on = gate_is_on(gate_state_in);
    end
    case (r.state)
      // Normal running, user shutdown or latched trip leave it
      hot_swap_pkg::ST_RUN: begin
        if (shutdown_req_in) begin
          next_r.state = hot_swap_pkg::ST_SHUTDOWN;
          next_r.lockout_low = 1'b1;
        end else if (LATCHED_VARIANT && r.gate_was_on &&
                     gate_state_in == hot_swap_pkg::GATE_OFF_MODERATE &&
                     lockout_in) begin
          // Timeout turned the switch off and it stays latched
          next_r.state = hot_swap_pkg::ST_FAULT;
          next_r.fault_latched = 1'b1;
        end
      end

      // Lockout held low for as long as the user asks
      hot_swap_pkg::ST_SHUTDOWN: begin
        next_r.lockout_low = 1'b1;
        if (!shutdown_req_in) begin
          next_r.lockout_low = 1'b0;
          if (r.fault_latched) begin
            next_r.state = hot_swap_pkg::ST_WAIT_TIMER;
          end else begin
            next_r.state = hot_swap_pkg::ST_SETTLE;
            next_r.count = hot_swap_pkg::COUNT_ZERO;
          end
        end
      end

      // Latched off, waiting for the user to ask for a restart
      hot_swap_pkg::ST_FAULT: begin
        if (shutdown_req_in) begin
          next_r.state = hot_swap_pkg::ST_SHUTDOWN;
          next_r.lockout_low = 1'b1;
        end else if (restart_req_in) begin
          next_r.state = hot_swap_pkg::ST_WAIT_TIMER;
        end
      end

      // Restart armed, waiting for the timer to fall
      hot_swap_pkg::ST_WAIT_TIMER: begin
        // A restart before the timer falls would not take effect
        if (shutdown_req_in) begin
          next_r.state = hot_swap_pkg::ST_SHUTDOWN;
          next_r.lockout_low = 1'b1;
        end else if (timer_low_in) begin
          next_r.state = hot_swap_pkg::ST_PULSE;
          next_r.count = hot_swap_pkg::COUNT_ZERO;
          if (RESTART_BY_SUPPLY) begin
            next_r.supply_off = 1'b1;
          end else begin
            next_r.lockout_low = 1'b1;
          end
        end
      end

      // Restart pulse of fixed length on lockout or supply
      hot_swap_pkg::ST_PULSE: begin
        if (count_done(r.count, PULSE_CYCLES)) begin
          next_r.state = hot_swap_pkg::ST_SETTLE;
          next_r.count = hot_swap_pkg::COUNT_ZERO;
          next_r.lockout_low = shutdown_req_in;
          next_r.supply_off = 1'b0;
          next_r.fault_latched = 1'b0;
          next_r.restart_done = 1'b1;
        end else begin
          next_r.count = r.count + 16'h0001;
        end
      end

      // Grace time while the device powers the load up again
      hot_swap_pkg::ST_SETTLE: begin
        // Device restarts with in-rush limiting; ignore gate edges
        if (shutdown_req_in) begin
          next_r.state = hot_swap_pkg::ST_SHUTDOWN;
          next_r.lockout_low = 1'b1;
        end else if (count_done(r.count, SETTLE_CYCLES)) begin
          next_r.state = hot_swap_pkg::ST_RUN;
          next_r.gate_was_on = 1'b0;
        end else begin
          next_r.count = r.count + 16'h0001;
        end
      end
      default: begin
        next_r.state = hot_swap_pkg::ST_RUN;
        next_r.lockout_low = 1'b0;
        next_r.supply_off = 1'b0;
      end
    endcase
  end

  // One register stage for all state; reset values are constants
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r.state <= hot_swap_pkg::ST_RUN;
      r.count <= hot_swap_pkg::COUNT_ZERO;
      r.lockout_low <= 1'b0;
      r.supply_off <= 1'b0;
      r.fault_latched <= 1'b0;
      r.gate_was_on <= 1'b0;
      r.restart_done <= 1'b0;
      r.load_good <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Open-drain lockout: drive low only, otherwise released
  assign lockout_out = 1'b0;
  assign lockout_oe_n_out = ~r.lockout_low;
  // Supply stays on unless a supply-cycle restart is running
  assign supply_enable_out = ~r.supply_off;
  // Power limit pin left open when the feature is unused
  assign power_limit_set_oe_n_out = ~USE_POWER_LIMIT;
  // Status outputs are straight register copies
  assign load_on_out = r.gate_was_on;
  assign load_good_out = r.load_good;
  assign fault_out = r.fault_latched;
  assign restart_pulse_out = r.restart_done;
  // Busy covers every state except RUN and FAULT
  assign busy_out = (r.state != hot_swap_pkg::ST_RUN) &&
                    (r.state != hot_swap_pkg::ST_FAULT);
endmodule

// ---- hot_swap_host_checker.sv ----
// Checker for the host restart and shutdown timing
`timescale 1ns/100ps
module hot_swap_host_checker (
  input wire logic ref_clk_in, // Clock
  input wire logic reset_n_in, // Reset
  input wire logic shutdown_req_in, // Load off
  input wire logic timer_low_in, // Timer low
  input wire logic lockout_oe_n_out, // Lockout pull
  input wire logic fault_out, // Fault
  input wire logic restart_pulse_out // Release pulse
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_release;
    lockout_oe_n_out && restart_pulse_out ##1 !restart_pulse_out;
  endsequence
  property p_shut;
    shutdown_req_in |=> !lockout_oe_n_out;
  endproperty
  property p_wait;
    $fell(lockout_oe_n_out) && fault_out && !$past(shutdown_req_in)
      |-> $past(timer_low_in);
  endproperty
  property p_clear;
    $fell(fault_out) |-> s_release;
  endproperty
  property p_hold;
    fault_out |=> fault_out || restart_pulse_out;
  endproperty
  a_shut: assert property (p_shut) else $error("lockout not pulled");
  a_wait: assert property (p_wait) else $error("early restart");
  a_clear: assert property (p_clear) else $error("bad release");
  a_hold: assert property (p_hold) else $error("fault dropped");
endmodule
bind hot_swap_host hot_swap_host_checker chk (.ref_clk_in, .reset_n_in,
  .shutdown_req_in, .timer_low_in, .lockout_oe_n_out, .fault_out,
  .restart_pulse_out);

// ---- hot_swap_dev_model.sv ----
// Latched-fault device model seen from its pins
`timescale 1ns/100ps
module hot_swap_dev_model #(
  parameter int TMAX = 8
) (
  input wire logic ref_clk_in, // Clock
  input wire logic reset_n_in, // Power-on reset
  input wire logic lockout_in, // Lockout wire
  input wire logic limit_in, // Overload
  output logic [1:0] gate_out, // Gate state
  output logic timer_low_out, // Timer low
  output logic good_out // Power good
);
  logic [7:0] timer;
  logic [7:0] timer_dec;
  logic latched;
  assign timer_dec = timer - 8'(timer != 8'h00);
  assign timer_low_out = timer < 8'h03;
  assign good_out = lockout_in;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer <= 8'h00;
      latched <= 1'b0;
      gate_out <= hot_swap_pkg::GATE_OFF_STRONG;
    end else if (!lockout_in || latched) begin
      gate_out <= hot_swap_pkg::GATE_OFF_MODERATE;
      timer <= timer_dec;
      if (!lockout_in && timer_low_out) latched <= 1'b0;
    end else if (limit_in) begin
      gate_out <= hot_swap_pkg::GATE_LIMITING;
      timer <= timer + 8'h01;
      if (timer == 8'(TMAX - 1)) begin
        latched <= 1'b1;
        gate_out <= hot_swap_pkg::GATE_OFF_MODERATE;
      end
    end else begin
      gate_out <= hot_swap_pkg::GATE_ON;
      timer <= timer_dec;
    end
  end
endmodule

// ---- hot_swap_host_tb.sv ----
// Bench for the host against the device model
`timescale 1ns/100ps
module hot_swap_host_tb;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic shut = 1'b0;
  logic rst = 1'b0;
  logic limit = 1'b0;
  logic [1:0] gate;
  logic tlow, pg, lval, oe_n, plim, busy, fault;
  logic lon, lgood, supen, rpulse;
  wire lock = oe_n ? 1'b1 : lval;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  hot_swap_host #(.PULSE_CYCLES(2), .SETTLE_CYCLES(2)) uut (
    .ref_clk_in, .reset_n_in, .shutdown_req_in(shut), .restart_req_in(rst),
    .gate_state_in(gate), .timer_low_in(tlow), .power_good_output_in(pg),
    .lockout_in(lock), .lockout_out(lval), .lockout_oe_n_out(oe_n),
    .supply_enable_out(supen), .power_limit_set_oe_n_out(plim),
    .load_on_out(lon), .load_good_out(lgood), .fault_out(fault),
    .restart_pulse_out(rpulse),
    .busy_out(busy));
  hot_swap_dev_model dev (.ref_clk_in, .reset_n_in, .lockout_in(lock),
    .limit_in(limit), .gate_out(gate), .timer_low_out(tlow), .good_out(pg));
  task chk(string name, logic [1:0] exp, logic [1:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_of_test;
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task t_brief;
    limit <= 1'b1;
    tick(3);
    limit <= 1'b0;
    tick(4);
    @(negedge ref_clk_in);
    chk("gate", hot_swap_pkg::GATE_ON, gate);
    chk("fault", 2'h0, 2'(fault));
    chk("load on", 2'h1, 2'(lon));
    chk("load good", 2'h1, 2'(lgood));
  endtask
  task t_shutdown;
    @(posedge ref_clk_in) shut <= 1'b1;
    tick(2);
    @(negedge ref_clk_in);
    chk("lockout", 2'h0, 2'(lock));
    chk("gate", hot_swap_pkg::GATE_OFF_MODERATE, gate);
    chk("load good", 2'h0, 2'(lgood));
    chk("supply", 2'h1, 2'(supen));
    @(posedge ref_clk_in) shut <= 1'b0;
    tick(6);
    @(negedge ref_clk_in);
    chk("gate", hot_swap_pkg::GATE_ON, gate);
  endtask
  task t_fault;
    int i;
    int seen;
    seen = 0;
    @(posedge ref_clk_in) limit <= 1'b1;
    for (i = 0; i < 20 && fault !== 1'b1; i++) @(negedge ref_clk_in);
    chk("fault", 2'h1, 2'(fault));
    chk("gate", hot_swap_pkg::GATE_OFF_MODERATE, gate);
    @(posedge ref_clk_in) limit <= 1'b0;
    rst <= 1'b1;
    @(posedge ref_clk_in) rst <= 1'b0;
    tick(2);
    for (i = 0; i < 40 && busy !== 1'b0; i++) begin
      @(negedge ref_clk_in);
      if (rpulse === 1'b1) seen++;
    end
    chk("restart pulse", 2'h1, 2'(seen));
    tick(2);
    @(negedge ref_clk_in);
    chk("fault", 2'h0, 2'(fault));
    chk("gate", hot_swap_pkg::GATE_ON, gate);
    chk("load on", 2'h1, 2'(lon));
    chk("supply", 2'h1, 2'(supen));
  endtask
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    tick(6);
    reset_n_in <= 1'b1;
    tick(8);
    chk("power limit pin", 2'h1, 2'(plim));
    t_brief;
    t_shutdown;
    t_fault;
    end_of_test;
  end
endmodule
